/* hw/hwr_edge.sv */
// Purpose: Rising-edge detector that turns the crystal level into a tick pulse.
// Assumes: Input is synchronous to the system clock.
// Notes: One-cycle pulse on each low-to-high change.
`timescale 1ns/1ps
module hwr_edge (
    input  wire logic sys_clk_in,   // System clock.
    input  wire logic rst_in,       // Synchronous reset, active high.
    input  wire logic level_in,     // Slow level to watch.
    output logic      tick_out      // One-cycle pulse on rising edge.
);
    logic prev;       // Last sampled level.
    logic next_prev;  // Next sampled level.

    // The next value is simply the current input.
    always_comb begin
        next_prev = level_in;
    end

    // Register the level; reset forces a known low.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // Pulse when the level has just risen.
    assign tick_out = level_in & ~prev;
endmodule

/* hw/hwr_pkg.sv */
// Purpose: Shared constants for the hardware watchdog and reset sequencer.
// Assumes: One 250 MHz system clock; the 32 kHz crystal tick arrives as a level input.
// Notes: Contract
// Contract
// R1 - Firmware refreshes watchdog within 1.5 seconds.
// R2 - Watchdog counts crystal ticks, resets on overflow.
// R3 - Overflow holds processor 4096 ticks, boots 0x0000.
// R4 - Emulator enable keeps watchdog inactive.
// R5 - Fault sense tied to rail disables both.
// R6 - No firmware path disables watchdog or oscillator.
// R7 - Reset pin halts logic, restores I/O defaults.
// R8 - Reset persists 4096 RTC ticks after release.
// R9 - Comparator fall clears PLL status, powers down.
// R10 - Power return holds reset 2048..4096 ticks.
// R11 - Each refresh restarts watchdog count from zero.
package hwr_pkg;
    // Crystal frequency in Hz and watchdog timeout in milliseconds.
    localparam int unsigned XTAL_HZ        = 32768;
    localparam int unsigned WDOG_TIMEOUT_MS = 1500;
    // Watchdog overflow count in crystal ticks, rounded down.
    localparam int unsigned WDOG_TICKS     = (XTAL_HZ * WDOG_TIMEOUT_MS) / 1000;
    // Hold counts in crystal ticks.
    localparam int unsigned HOLD_TICKS     = 4096;
    localparam int unsigned PWR_MIN_TICKS  = 2048;
    // Width of the tick counters.
    localparam int unsigned CNT_W          = 16;
    // Boot address presented on release.
    localparam logic [15:0] BOOT_ADDR      = 16'h0000;
    // Reason codes for the last reset.
    typedef enum logic [1:0] {
        HWR_CAUSE_PIN,
        HWR_CAUSE_WDOG,
        HWR_CAUSE_POWER
    } hwr_cause_t;
endpackage

/* hw/hwr_watchdog_reset_sequencer.sv */
// Purpose: Fixed-duration watchdog plus reset and power-fault sequencing.
// Assumes: All inputs synchronous to sys_clk_in; crystal runs during every reset.
// Notes: No firmware input can stop the watchdog; only pins disable it.
`timescale 1ns/1ps
module hwr_watchdog_reset_sequencer (
    input  wire logic        sys_clk_in,        // System clock, 250 MHz.
    input  wire logic        rst_in,            // Power-on reset, synchronous, active high.
    input  wire logic        slow_clock_32k_in, // Crystal time base level.
    input  wire logic        refresh_in,        // Firmware refresh strobe.
    input  wire logic        emulator_enable_in,// Emulator enable pin.
    input  wire logic        sense_at_rail_in,  // Fault sense tied to supply_3v3_rail.
    input  wire logic        fault_cmp_in,      // High while sense exceeds threshold bias.
    input  wire logic        ext_reset_in,      // External reset pin, active high.
    output logic             cpu_reset_out,     // Holds the processor in reset.
    output logic             io_defaults_out,   // Pulse: restore I/O configuration defaults.
    output logic             pll_clear_out,     // Pulse: clear PLL status bits.
    output logic             power_down_out,    // Level: digital section powered down.
    output logic             ram_init_out,      // Pulse on release after power return.
    output logic [15:0]      boot_addr_out,     // Start address on release.
    output logic             wdog_overflow_out, // Pulse on watchdog overflow.
    output hwr_pkg::hwr_cause_t cause_out       // Reason for the last reset.
);
    // Sequencer states.
    typedef enum logic [2:0] {
        HWR_RUN,
        HWR_PIN_HELD,
        HWR_HOLD,
        HWR_DOWN
    } hwr_state_t;

    logic                 tick;          // One-cycle crystal tick.
    hwr_state_t           state;         // Current sequencer state.
    hwr_state_t           next_state;    // Next sequencer state.
    logic [15:0]          wcnt;          // Watchdog tick count.
    logic [15:0]          next_wcnt;     // Next watchdog count.
    logic [15:0]          hcnt;          // Hold tick count.
    logic [15:0]          next_hcnt;     // Next hold count.
    logic [15:0]          hold_len;      // Ticks to hold in this reset.
    logic [15:0]          next_hold_len; // Next hold length.
    hwr_pkg::hwr_cause_t  next_cause;    // Next reset reason.
    logic                 wd_active;     // Watchdog allowed to count.
    logic                 fault_en;      // Power-fault detection allowed.
    logic                 wd_ovf;        // Overflow this cycle.
    logic                 pwr_fail;      // Power fault seen this cycle.

    // Crystal level to tick pulse.
    hwr_edge u_edge (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .level_in   (slow_clock_32k_in),
        .tick_out   (tick)
    );

    // R4 emulator disables watchdog.
    // R5 rail tie disables both.
    assign wd_active = ~emulator_enable_in & ~sense_at_rail_in & (state == HWR_RUN);
    assign fault_en  = ~sense_at_rail_in;
    assign pwr_fail  = fault_en & ~fault_cmp_in;
    // R2 overflow on crystal count.
    assign wd_ovf    = wd_active & tick & ~refresh_in
                     & (wcnt == 16'(hwr_pkg::WDOG_TICKS - 1));

    // Next-state logic for the sequencer and its counters.
    always_comb begin
        next_state    = state;
        next_wcnt     = wcnt;
        next_hcnt     = hcnt;
        next_hold_len = hold_len;
        next_cause    = cause_out;
        // R11 refresh restarts count.
        if (!wd_active || refresh_in) begin
            next_wcnt = 16'h0000;
        end else if (tick) begin
            next_wcnt = wcnt + 16'h0001;
        end
        case (state)
            HWR_RUN: begin
                if (pwr_fail) begin
                    // R9 fall powers down.
                    next_state = HWR_DOWN;
                    next_cause = hwr_pkg::HWR_CAUSE_POWER;
                end else if (ext_reset_in) begin
                    // R7 pin halts activity.
                    next_state = HWR_PIN_HELD;
                    next_cause = hwr_pkg::HWR_CAUSE_PIN;
                end else if (wd_ovf) begin
                    // R3 hold after overflow.
                    next_state    = HWR_HOLD;
                    next_hcnt     = 16'h0000;
                    next_hold_len = 16'(hwr_pkg::HOLD_TICKS);
                    next_cause    = hwr_pkg::HWR_CAUSE_WDOG;
                end
            end
            HWR_PIN_HELD: begin
                if (pwr_fail) begin
                    next_state = HWR_DOWN;
                    next_cause = hwr_pkg::HWR_CAUSE_POWER;
                end else if (!ext_reset_in) begin
                    // R8 timer starts at release.
                    next_state    = HWR_HOLD;
                    next_hcnt     = 16'h0000;
                    next_hold_len = 16'(hwr_pkg::HOLD_TICKS);
                end
            end
            HWR_HOLD: begin
                if (pwr_fail) begin
                    next_state = HWR_DOWN;
                    next_cause = hwr_pkg::HWR_CAUSE_POWER;
                end else if (ext_reset_in) begin
                    next_state = HWR_PIN_HELD;
                end else if (tick) begin
                    if (hcnt == hold_len - 16'h0001) begin
                        next_state = HWR_RUN;
                    end else begin
                        next_hcnt = hcnt + 16'h0001;
                    end
                end
            end
            HWR_DOWN: begin
                if (!pwr_fail) begin
                    // R10 power return hold.
                    next_state    = HWR_HOLD;
                    next_hcnt     = 16'h0000;
                    next_hold_len = 16'(hwr_pkg::PWR_MIN_TICKS);
                end
            end
            default: begin
                next_state = HWR_HOLD;
            end
        endcase
    end

    // R6 only pins, power and watchdog overflow reset this state.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state     <= HWR_HOLD;
            wcnt      <= 16'h0000;
            hcnt      <= 16'h0000;
            hold_len  <= 16'(hwr_pkg::PWR_MIN_TICKS);
            cause_out <= hwr_pkg::HWR_CAUSE_POWER;
        end else begin
            state     <= next_state;
            wcnt      <= next_wcnt;
            hcnt      <= next_hcnt;
            hold_len  <= next_hold_len;
            cause_out <= next_cause;
        end
    end

    // Registered pulse outputs; the level outputs are assigned below.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wdog_overflow_out <= 1'b0;
            io_defaults_out   <= 1'b0;
            pll_clear_out     <= 1'b0;
            ram_init_out      <= 1'b0;
        end else begin
            wdog_overflow_out <= (state == HWR_RUN) & ~pwr_fail & ~ext_reset_in & wd_ovf;
            // R7 pin restores I/O defaults; watchdog keeps them.
            io_defaults_out   <= (next_state == HWR_PIN_HELD) & (state != HWR_PIN_HELD);
            pll_clear_out     <= (next_state == HWR_DOWN) & (state != HWR_DOWN);
            ram_init_out      <= (state == HWR_HOLD) & (next_state == HWR_RUN)
                               & (cause_out == hwr_pkg::HWR_CAUSE_POWER);
        end
    end

    assign cpu_reset_out  = (state != HWR_RUN);
    assign power_down_out = (state == HWR_DOWN);
    // R3 start at boot address.
    assign boot_addr_out  = hwr_pkg::BOOT_ADDR;

    // Checks of the contract rules below, tagged by rule number.
    property p_ovf_holds;
        @(posedge sys_clk_in) disable iff (rst_in)
        wdog_overflow_out |-> cpu_reset_out && cause_out == hwr_pkg::HWR_CAUSE_WDOG;
    endproperty
    a_ovf_holds: assert property (p_ovf_holds) else $error("overflow without reset"); // R2

    property p_wdog_hold_len;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(cpu_reset_out) && cause_out == hwr_pkg::HWR_CAUSE_WDOG |-> hold_len == 16'd4096;
    endproperty
    a_wdog_hold_len: assert property (p_wdog_hold_len) else $error("bad hold"); // R3

    property p_emu_quiet;
        @(posedge sys_clk_in) disable iff (rst_in)
        emulator_enable_in |=> !wdog_overflow_out;
    endproperty
    a_emu_quiet: assert property (p_emu_quiet) else $error("overflow under emulator"); // R4

    property p_rail_quiet;
        @(posedge sys_clk_in) disable iff (rst_in)
        sense_at_rail_in |=> !wdog_overflow_out && !pll_clear_out;
    endproperty
    a_rail_quiet: assert property (p_rail_quiet) else $error("active while disabled"); // R5

    property p_pin_halts;
        @(posedge sys_clk_in) disable iff (rst_in)
        ext_reset_in |=> cpu_reset_out;
    endproperty
    a_pin_halts: assert property (p_pin_halts) else $error("pin did not halt"); // R7

    property p_release_waits;
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(ext_reset_in) && !power_down_out |=> cpu_reset_out [*8];
    endproperty
    a_release_waits: assert property (p_release_waits) else $error("early release"); // R8

    property p_fault_clear;
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(power_down_out) |-> pll_clear_out;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("PLL not cleared"); // R9

    property p_power_return;
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(power_down_out) |-> hold_len == 16'd2048 && cpu_reset_out;
    endproperty
    a_power_return: assert property (p_power_return) else $error("bad power hold"); // R10

    property p_refresh_zero;
        @(posedge sys_clk_in) disable iff (rst_in)
        refresh_in |=> wcnt == 16'h0000;
    endproperty
    a_refresh_zero: assert property (p_refresh_zero) else $error("count kept"); // R11

    c_overflow: cover property (@(posedge sys_clk_in) wdog_overflow_out);
    c_pin:      cover property (@(posedge sys_clk_in) $fell(ext_reset_in));
    c_power:    cover property (@(posedge sys_clk_in) ram_init_out);
endmodule

/* verification/hwr_fw_model.sv */
// Purpose: Firmware stand-in that refreshes the watchdog on a tick interval.
// Assumes: Crystal level is sampled on falling system clock edges.
// Notes: Interval is in crystal ticks; disabling stops all refreshes.
`timescale 1ns/1ps
module hwr_fw_model (
    input  wire logic        sys_clk_in,        // System clock.
    input  wire logic        slow_clock_32k_in, // Crystal level.
    input  wire logic        enable_in,         // Firmware is running.
    input  wire logic [15:0] interval_in,       // Ticks between refreshes.
    output logic             refresh_out        // One-cycle refresh pulse.
);
    logic        last_level; // Previous crystal level.
    logic [15:0] count;      // Ticks since the last refresh.
    initial begin
        refresh_out = 1'b0;
        last_level = 1'b0;
        count = 16'h0000;
    end
    // Counts ticks and pulses the refresh when the interval is reached.
    always @(negedge sys_clk_in) begin
        refresh_out <= 1'b0;
        last_level <= slow_clock_32k_in;
        if (!enable_in) begin
            count <= 16'h0000;
        end else if (slow_clock_32k_in && !last_level) begin
            if (count + 16'h0001 >= interval_in) begin
                refresh_out <= 1'b1;
                count <= 16'h0000;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for the watchdog and reset sequencer.
// Assumes: Crystal is compressed to one tick every two system cycles.
// Notes: Pulses are matched against a queue of expected notes.
`timescale 1ns/1ps
module testbench;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, xtal = 1'b0, fw_en = 1'b0;
    logic emu = 1'b0, rail = 1'b0, cmp = 1'b1, pin = 1'b0, refresh;
    logic cpu_rst, io_def, pll_clr, pdown, ram_init, wd_ovf;
    logic [15:0] boot, interval = 16'h0040;
    hwr_pkg::hwr_cause_t cause;
    logic [5:0]  notes[$];   // Expected pulse set and cause.
    logic [5:0]  seen;       // Observed pulse set and cause.
    int          fails = 0, compares = 0, cycles = 0, k, seed = 80737;
    always #2 sys_clk_in = ~sys_clk_in;
    // The crystal keeps running through every reset.
    always @(negedge sys_clk_in) xtal <= ~xtal;
    hwr_watchdog_reset_sequencer dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .slow_clock_32k_in(xtal), .refresh_in(refresh), .emulator_enable_in(emu),
        .sense_at_rail_in(rail), .fault_cmp_in(cmp), .ext_reset_in(pin),
        .cpu_reset_out(cpu_rst), .io_defaults_out(io_def), .pll_clear_out(pll_clr),
        .power_down_out(pdown), .ram_init_out(ram_init), .boot_addr_out(boot),
        .wdog_overflow_out(wd_ovf), .cause_out(cause));
    hwr_fw_model fw (.sys_clk_in(sys_clk_in), .slow_clock_32k_in(xtal),
        .enable_in(fw_en), .interval_in(interval), .refresh_out(refresh));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge xtal);
    endtask
    // Holds at least lo ticks, releases by hi ticks.
    task automatic hold(input int lo, input int hi);
        wait_ticks(lo);
        check(cpu_rst, 1'b1);
        k = lo;
        while (cpu_rst === 1'b1 && k < hi) begin
            wait_ticks(1);
            k++;
        end
        check(cpu_rst, 1'b0);
    endtask
    // Cuts a hang short.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 150000) begin
            fails++;
            tally_and_finish();
        end
    end
    // Matches every pulse against the oldest note; cause is read a cycle later.
    always @(negedge sys_clk_in) begin
        if (!rst_in && (io_def | pll_clr | ram_init | wd_ovf) === 1'b1) begin
            seen[5:2] = {io_def, pll_clr, ram_init, wd_ovf};
            @(negedge sys_clk_in);
            seen[1:0] = cause;
            if (notes.size() == 0) check(seen, 6'h3f);
            else check(seen, notes.pop_front());
        end
    end
    initial begin
        notes.push_back({4'b0010, 2'(hwr_pkg::HWR_CAUSE_POWER)});
        repeat (4) @(negedge sys_clk_in);
        rst_in = 1'b0;
        hold(2046, 4100);
        check(boot, 16'h0000);
        fw_en = 1'b1;
        // random intervals stay far below the timeout
        repeat (4) begin
            interval = 16'h0010 + 16'($unsigned($random(seed)) % 240);
            wait_ticks(250);
        end
        check(cpu_rst, 1'b0);
        fw_en = 1'b0;
        emu = 1'b1;
        wait_ticks(500);
        emu = 1'b0;
        rail = 1'b1;
        cmp = 1'b0;
        wait_ticks(500);
        check(pdown, 1'b0);
        cmp = 1'b1;
        rail = 1'b0;
        notes.push_back({4'b0001, 2'(hwr_pkg::HWR_CAUSE_WDOG)});
        wait_ticks(49150);
        check(cpu_rst, 1'b0);
        k = 0;
        while (cpu_rst !== 1'b1 && k < 8) begin
            wait_ticks(1);
            k++;
        end
        check(cpu_rst, 1'b1);
        fw_en = 1'b1;
        hold(4094, 4100);
        check(boot, 16'h0000);
        notes.push_back({4'b1000, 2'(hwr_pkg::HWR_CAUSE_PIN)});
        pin = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        check(cpu_rst, 1'b1);
        pin = 1'b0;
        hold(4094, 4100);
        notes.push_back({4'b0100, 2'(hwr_pkg::HWR_CAUSE_POWER)});
        cmp = 1'b0;
        repeat (8) @(negedge sys_clk_in);
        check(pdown, 1'b1);
        notes.push_back({4'b0010, 2'(hwr_pkg::HWR_CAUSE_POWER)});
        cmp = 1'b1;
        hold(2046, 4100);
        repeat (10) @(negedge sys_clk_in);
        check(16'(notes.size()), 16'h0000);
        tally_and_finish();
    end
endmodule
